// ===== verilog/pin_power_ctrl.sv
// Power-down, self-test strap and pin function control with an Avalon-MM slave.
//
// Function
// - Raising power_down_n enables the device and loads every register default.
// - power_down_n low tri-states all pin outputs and stops the PLL.
// - self_test_enable low disables self-test; high enters self-test mode.
// - In self-test, clock select low picks pixel clock, high internal 33 MHz.
// - Clock select acts as test clock choice only during self-test.
// - Outside self-test the shared pin is the external interrupt input.
// - After reset, pins 0-3 and 9 are outputs driving low; registers reassign.
// - Pin 0 selects GPIO, serial audio data, or self-test pass.
// - Fast pins work only in dual-link mode and reset to tri-state.
// - Registers select fast pins as GPIO or as SPI MOSI and MISO.
`timescale 1ns/1ps
`include "pin_ctrl_defs.svh"

module pin_power_ctrl
    import pin_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic power_down_n,
    input wire logic self_test_enable,
    input wire logic self_test_clock_select,
    input wire logic self_test_pass,
    input wire audio_alt_t audio_alt,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic [4:0] gp_pin_in,
    output logic [4:0] gp_pin_out,
    output logic [4:0] gp_pin_oe,
    input wire logic [1:0] fast_gp_pin_in,
    output logic [1:0] fast_gp_pin_out,
    output logic [1:0] fast_gp_pin_oe,
    output logic pll_enable,
    output logic self_test_active,
    output logic test_clock_internal,
    output logic external_interrupt_in
);

    // ----------------------------------------
    // Reset image and helpers
    // ----------------------------------------
    localparam state_t RESET_ST = '{
        pwr: PWR_OFF,
        ctrl: `CTRL_RESET,
        func: `FUNC_RESET,
        dir: `DIR_RESET,
        out: `OUT_RESET,
        gp_o: 5'h00,
        gp_oe: 5'h00,
        fp_o: 2'h0,
        fp_oe: 2'h0,
        st_active: 1'b0,
        clk_int: 1'b0,
        ext_int: 1'b0,
        pll_en: 1'b0,
        miso: 1'b0,
        waitreq: 1'b1,
        rdata: 32'h0000_0000
    };

    // Returns {out, oe} for a pin that is either GPIO or an alternate output.
    function automatic logic [1:0] pin_sel(
        input logic alt_en,
        input logic alt_v,
        input logic g_o,
        input logic g_oe
    );
        if (alt_en)
            pin_sel = {alt_v, 1'b1};
        else
            pin_sel = {g_o, g_oe};
    endfunction : pin_sel

    state_t st;
    state_t next_st;
    logic [`SYNC_W-1:0] sy;
    logic pd_n;
    logic ste;
    logic csel;
    logic [4:0] gpi;
    logic [1:0] fpi;
    logic run;
    logic dual;
    logic spi;
    logic [3:0] alt_v;

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    pin_sync u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in({fast_gp_pin_in, gp_pin_in, self_test_clock_select,
            self_test_enable, power_down_n}),
        .pin_sync_out(sy)
    );

    // Straps and GPIO inputs are used only as synchronised copies; spi_mosi, self_test_pass and audio_alt are not.
    assign pd_n = sy[0];
    assign ste = sy[1];
    assign csel = sy[2];
    assign gpi = sy[7:3];
    assign fpi = sy[9:8];
    assign run = (st.pwr == PWR_RUN);
    assign dual = st.ctrl[`CTRL_DUAL_BIT];
    assign spi = st.ctrl[`CTRL_SPI_BIT];
    assign alt_v = {audio_alt.audio_master_clock, audio_alt.audio_data_out_d,
        audio_alt.audio_data_out_c, audio_alt.audio_word_clock_alt};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic [1:0] ps;
        ps = 2'h0;
        next_st = st;
        next_st.waitreq = 1'b1;

        // Power sequencing: defaults are reloaded on every wake-up.
        case (st.pwr)
            PWR_OFF:
            begin
                next_st = RESET_ST;
                if (pd_n)
                    next_st.pwr = PWR_INIT;
            end
            PWR_INIT:
            begin
                next_st = RESET_ST;
                next_st.pwr = PWR_RUN;
            end
            PWR_RUN:
            begin
                if (!pd_n)
                    next_st = RESET_ST;
            end
            default:
            begin
                next_st = RESET_ST;
            end
        endcase

        // Avalon-MM slave: one wait cycle, then the access completes.
        next_st.waitreq = 1'b1;
        if ((read || write) && st.waitreq)
        begin
            next_st.waitreq = 1'b0;
            case (address)
                `CTRL_OFS: next_st.rdata = {30'h0, st.ctrl};
                `FUNC_OFS: next_st.rdata = {26'h0, st.func};
                `DIR_OFS: next_st.rdata = {25'h0, st.dir};
                `OUT_OFS: next_st.rdata = {25'h0, st.out};
                `IN_OFS: next_st.rdata = {25'h0, fpi, gpi};
                `STAT_OFS:
                    next_st.rdata = {28'h0, st.ext_int, st.clk_int,
                        st.st_active, run};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (write && !st.waitreq && run && pd_n)
        begin
            case (address)
                `CTRL_OFS: next_st.ctrl = writedata[1:0];
                `FUNC_OFS: next_st.func = writedata[5:0];
                `DIR_OFS: next_st.dir = writedata[6:0];
                `OUT_OFS: next_st.out = writedata[6:0];
                default: next_st.out = st.out;
            endcase
        end

        // Mode straps: the shared pin has one meaning at a time.
        next_st.pll_en = (st.pwr != PWR_OFF);
        next_st.st_active = run && ste;
        next_st.clk_int = run && ste && csel;
        next_st.ext_int = run && !ste && csel;

        // General-purpose pins; outputs are dropped while powered down.
        if (run)
        begin
            case (st.func[`FUNC_GP0_LSB +: 2])
                `GP0_AUDIO:
                    ps = {audio_alt.audio_serial_data_out, 1'b1};
                `GP0_PASS:
                    ps = {self_test_pass, 1'b1};
                default:
                    ps = {st.out[0], st.dir[0]};
            endcase
            next_st.gp_o[0] = ps[1];
            next_st.gp_oe[0] = ps[0];
            for (int i = 1; i < 5; i++)
            begin
                ps = pin_sel(st.func[`FUNC_ALT_LSB + i - 1], alt_v[i - 1],
                    st.out[i], st.dir[i]);
                next_st.gp_o[i] = ps[1];
                next_st.gp_oe[i] = ps[0];
            end
        end
        else
        begin
            next_st.gp_o = 5'h00;
            next_st.gp_oe = 5'h00;
        end

        // Fast pins: idle unless dual-link mode is set.
        next_st.miso = 1'b0;
        if (!run || !dual)
        begin
            next_st.fp_o = 2'h0;
            next_st.fp_oe = 2'h0;
        end
        else if (spi)
        begin
            next_st.fp_o = {1'b0, spi_mosi};
            next_st.fp_oe = 2'h1;
            next_st.miso = fpi[1];
        end
        else
        begin
            next_st.fp_o = st.out[6:5];
            next_st.fp_oe = st.dir[6:5];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st <= RESET_ST;
        else
            st <= next_st;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign readdata = st.rdata;
    assign waitrequest = st.waitreq;
    assign spi_miso = st.miso;
    assign gp_pin_out = st.gp_o;
    assign gp_pin_oe = st.gp_oe;
    assign fast_gp_pin_out = st.fp_o;
    assign fast_gp_pin_oe = st.fp_oe;
    assign pll_enable = st.pll_en;
    assign self_test_active = st.st_active;
    assign test_clock_internal = st.clk_int;
    assign external_interrupt_in = st.ext_int;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    pd_drop_a: assert property (
        run && !pd_n |=> st.pwr == PWR_OFF ##1 (gp_pin_oe == 5'h00
        && fast_gp_pin_oe == 2'h0 && !pll_enable))
        else $error("power-down did not tri-state the pins");

    wake_init_a: assert property (
        st.pwr == PWR_OFF && pd_n |=> st.pwr == PWR_INIT
        ##1 (run && st.dir == `DIR_RESET && st.ctrl == `CTRL_RESET))
        else $error("wake-up did not load the defaults");

    test_mode_a: assert property (
        run && pd_n |=> self_test_active == $past(ste))
        else $error("self-test mode does not follow its strap");

    clk_sel_a: assert property (
        run && ste && csel |=> test_clock_internal)
        else $error("internal test clock not selected");

    csel_gate_a: assert property (
        test_clock_internal |-> self_test_active && !external_interrupt_in)
        else $error("clock select used outside self-test");

    ext_int_a: assert property (
        run && !ste |=> external_interrupt_in == $past(csel))
        else $error("interrupt input does not follow the shared pin");

    gp_low_a: assert property (
        st.pwr == PWR_INIT |-> ##2 (gp_pin_oe == 5'h1f
        && gp_pin_out == 5'h00))
        else $error("pins do not drive low after wake-up");

    gp0_pass_a: assert property (
        run && st.func[1:0] == `GP0_PASS |=> gp_pin_oe[0]
        && gp_pin_out[0] == $past(self_test_pass))
        else $error("pin 0 does not show the pass flag");

    fast_dual_a: assert property (
        !dual |=> fast_gp_pin_oe == 2'h0)
        else $error("fast pins driven outside dual-link mode");

    spi_map_a: assert property (
        run && dual && spi |=> fast_gp_pin_oe == 2'h1
        && fast_gp_pin_out[0] == $past(spi_mosi)
        && spi_miso == $past(fpi[1]))
        else $error("fast pins not mapped to SPI");

    off_defaults_a: assert property (
        !run |=> st.ctrl == `CTRL_RESET && st.func == `FUNC_RESET
        && st.dir == `DIR_RESET && st.out == `OUT_RESET)
        else $error("registers left their defaults while not running");

    gp_off_a: assert property (
        !run |=> gp_pin_oe == 5'h00 && fast_gp_pin_oe == 2'h0)
        else $error("pins driven while not running");

    pll_off_a: assert property (
        st.pwr == PWR_OFF |=> !pll_enable)
        else $error("PLL running while powered down");

    mode_off_a: assert property (
        !run |=> !self_test_active && !test_clock_internal && !external_interrupt_in)
        else $error("mode outputs set while not running");

    gp0_audio_a: assert property (
        run && st.func[1:0] == `GP0_AUDIO |=> gp_pin_oe[0]
        && gp_pin_out[0] == $past(audio_alt.audio_serial_data_out))
        else $error("pin 0 does not show the audio data");

    fast_gpio_a: assert property (
        run && dual && !spi |=> fast_gp_pin_oe == $past(st.dir[6:5])
        && fast_gp_pin_out == $past(st.out[6:5]))
        else $error("fast pins do not follow their registers");

    bus_wait_a: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle wide");

    wake_c: cover property (st.pwr == PWR_INIT ##1 run);
    test_clk_c: cover property (test_clock_internal);
    spi_c: cover property (run && dual && spi);
    gp0_audio_c: cover property (run && st.func[1:0] == `GP0_AUDIO);

endmodule : pin_power_ctrl

// ===== common/pin_ctrl_defs.svh
// Offsets, field positions and reset values of the pin control block.
`ifndef PIN_CTRL_DEFS_SVH
`define PIN_CTRL_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTRL_OFS 5'h00
`define FUNC_OFS 5'h04
`define DIR_OFS 5'h08
`define OUT_OFS 5'h0c
`define IN_OFS 5'h10
`define STAT_OFS 5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_DUAL_BIT 0
`define CTRL_SPI_BIT 1
`define FUNC_GP0_LSB 0
`define FUNC_ALT_LSB 2

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define GP0_GPIO 2'h0
`define GP0_AUDIO 2'h1
`define GP0_PASS 2'h2
`define CTRL_RESET 2'h0
`define FUNC_RESET 6'h00
`define DIR_RESET 7'h1f
`define OUT_RESET 7'h00
`define SYNC_W 10

`endif

// ===== common/pin_ctrl_pkg.sv
// Types shared by the pin control block and its input synchroniser.
package pin_ctrl_pkg;

    typedef enum logic [1:0] {PWR_OFF, PWR_INIT, PWR_RUN} pwr_t;

    typedef struct packed {
        logic audio_master_clock;
        logic audio_data_out_d;
        logic audio_data_out_c;
        logic audio_word_clock_alt;
        logic audio_serial_data_out;
    } audio_alt_t;

    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
    } sync_t;

    typedef struct packed {
        pwr_t pwr;
        logic [1:0] ctrl;
        logic [5:0] func;
        logic [6:0] dir;
        logic [6:0] out;
        logic [4:0] gp_o;
        logic [4:0] gp_oe;
        logic [1:0] fp_o;
        logic [1:0] fp_oe;
        logic st_active;
        logic clk_int;
        logic ext_int;
        logic pll_en;
        logic miso;
        logic waitreq;
        logic [31:0] rdata;
    } state_t;

endpackage : pin_ctrl_pkg

// ===== verilog/pin_sync.sv
// Two-flop synchroniser for the asynchronous pin inputs.
`timescale 1ns/1ps
`include "pin_ctrl_defs.svh"

module pin_sync
    import pin_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [`SYNC_W-1:0] pin_in,
    output logic [`SYNC_W-1:0] pin_sync_out
);

    sync_t st;
    sync_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign pin_sync_out = st.s2;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sync_delay_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n, 2) |-> pin_sync_out == $past(pin_in, 2))
        else $error("synchroniser output is not the pin two cycles back");

endmodule : pin_sync

// ===== dv/pin_host_model.sv
// Host processor GPIO model that sequences the power-down and strap pins.
`timescale 1ns/1ps

module pin_host_model
(
    input wire logic clk_sys,
    input wire logic supply_ok,
    input wire logic [3:0] ramp,
    input wire logic test_req,
    input wire logic sel_req,
    output logic power_down_n,
    output logic self_test_enable,
    output logic self_test_clock_select
);
    logic [3:0] wait_cnt = 4'h0;
    initial
    begin
        power_down_n = 1'b0;
        self_test_enable = 1'b0;
        self_test_clock_select = 1'b0;
    end
    // The pin is released only after the supplies have been good for ramp cycles.
    always @(posedge clk_sys)
    begin
        wait_cnt <= supply_ok ? wait_cnt + 4'((wait_cnt < ramp) ? 1 : 0) : 4'h0;
        power_down_n <= supply_ok && (wait_cnt >= ramp);
        self_test_enable <= test_req;
        self_test_clock_select <= sel_req;
    end
endmodule : pin_host_model

// ===== dv/pin_power_bist_gpio_control_tb.sv
// Self-checking bench for the pin power and function control block.
`timescale 1ns/1ps
`include "pin_ctrl_defs.svh"

module pin_power_bist_gpio_control_tb
    import pin_ctrl_pkg::*;
;
    logic clk_sys, reset_n, read, write, supply_ok, test_req, sel_req, waitrequest;
    logic power_down_n, self_test_enable, self_test_clock_select, self_test_pass, spi_mosi;
    logic spi_miso, pll_enable, self_test_active, test_clock_internal, external_interrupt_in;
    logic [4:0] address, gp_pin_in, gp_pin_out, gp_pin_oe;
    logic [31:0] writedata, readdata;
    logic [1:0] fast_gp_pin_in, fast_gp_pin_out, fast_gp_pin_oe;
    logic [3:0] ramp;
    audio_alt_t audio_alt;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    pin_power_ctrl uut (.clk_sys, .reset_n, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .power_down_n, .self_test_enable, .self_test_clock_select,
        .self_test_pass, .audio_alt, .spi_mosi, .spi_miso, .gp_pin_in, .gp_pin_out,
        .gp_pin_oe, .fast_gp_pin_in, .fast_gp_pin_out, .fast_gp_pin_oe, .pll_enable,
        .self_test_active, .test_clock_internal, .external_interrupt_in);

    pin_host_model host (.clk_sys, .supply_ok, .ramp, .test_req, .sel_req, .power_down_n,
        .self_test_enable, .self_test_clock_select);

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic give_verdict;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD read t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    // Holds the request until waitrequest is seen low, then lets one edge pass.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do
            @(posedge clk_sys);
        while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    always @(posedge clk_sys)
    begin
        if (read === 1'b1 && waitrequest === 1'b0)
            cmp_rd(readdata, exp_q.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    initial
    begin
        logic [6:0] v;
        logic e;
        {reset_n, read, write, address, writedata, gp_pin_in, fast_gp_pin_in} = '0;
        {self_test_pass, spi_mosi, audio_alt, supply_ok, test_req, sel_req} = '0;
        ramp = 4'h3;
        void'($urandom(32'hb4e77a6a));
        tick(5);
        reset_n <= 1'b1;
        tick(4);
        cmp({gp_pin_oe, fast_gp_pin_oe, pll_enable}, 0);
        bus(1'b1, `OUT_OFS, 32'h7f);
        rd(`OUT_OFS, 0);
        rd(`STAT_OFS, 0);
        $display("test powered down done");
        supply_ok <= 1'b1;
        tick(12);
        cmp({pll_enable, gp_pin_oe, gp_pin_out, fast_gp_pin_oe}, 13'h1f80);
        rd(`CTRL_OFS, `CTRL_RESET);
        rd(`FUNC_OFS, `FUNC_RESET);
        rd(`DIR_OFS, `DIR_RESET);
        rd(`OUT_OFS, `OUT_RESET);
        rd(`STAT_OFS, 1);
        $display("test wake done");
        repeat (4)
        begin
            v = 7'($urandom());
            bus(1'b1, `DIR_OFS, {25'h0, v});
            bus(1'b1, `OUT_OFS, {25'h0, ~v});
            tick(2);
            cmp({gp_pin_oe, gp_pin_out, fast_gp_pin_oe}, {v[4:0], ~v[4:0], 2'b00});
            rd(`DIR_OFS, {25'h0, v});
        end
        $display("test gpio done");
        bus(1'b1, `DIR_OFS, 32'h7f);
        bus(1'b1, `OUT_OFS, 32'h41);
        bus(1'b1, `CTRL_OFS, 32'h1);
        tick(2);
        cmp({fast_gp_pin_oe, fast_gp_pin_out}, 4'b1110);
        spi_mosi <= 1'b1;
        fast_gp_pin_in <= 2'b10;
        bus(1'b1, `CTRL_OFS, 32'h3);
        tick(4);
        cmp({fast_gp_pin_oe, fast_gp_pin_out[0], spi_miso}, 4'b0111);
        bus(1'b1, `CTRL_OFS, 32'h0);
        $display("test fast pins done");
        for (int f = 0; f < 4; f++)
        begin
            audio_alt <= 5'($urandom());
            self_test_pass <= 1'($urandom());
            bus(1'b1, `FUNC_OFS, 32'h3c | f);
            tick(2);
            e = (f == 1) ? audio_alt[0] : (f == 2) ? self_test_pass : 1'b1;
            cmp(gp_pin_out, {audio_alt[4:1], e});
        end
        bus(1'b1, `FUNC_OFS, 32'h0);
        $display("test pin functions done");
        for (int m = 0; m < 4; m++)
        begin
            test_req <= m[1];
            sel_req <= m[0];
            tick(6);
            cmp({self_test_active, test_clock_internal, external_interrupt_in},
                {m[1], m[1] & m[0], ~m[1] & m[0]});
            rd(`STAT_OFS, {~m[1] & m[0], m[1] & m[0], m[1], 1'b1});
        end
        $display("test self-test done");
        v = 7'($urandom());
        gp_pin_in <= v[4:0];
        fast_gp_pin_in <= v[6:5];
        tick(4);
        rd(`IN_OFS, {25'h0, v});
        bus(1'b1, `IN_OFS, 32'h0);
        rd(`IN_OFS, {25'h0, v});
        bus(1'b1, 5'h18, 32'hff);
        rd(5'h18, 0);
        $display("test inputs done");
        bus(1'b1, `OUT_OFS, 32'h1f);
        supply_ok <= 1'b0;
        tick(6);
        cmp({gp_pin_oe, fast_gp_pin_oe, pll_enable, self_test_active}, 0);
        ramp <= 4'h9;
        supply_ok <= 1'b1;
        tick(20);
        rd(`OUT_OFS, `OUT_RESET);
        rd(`DIR_OFS, `DIR_RESET);
        $display("test power cycle done");
        give_verdict();
    end
endmodule : pin_power_bist_gpio_control_tb
